// >>> logic/uarx_regs.sv
// Summary of operation
// - outside loopback, status bit 7 reads the inverted carrier-detect pin.
// - in loopback, status bit 7 follows modem control bit 3 instead.
// - eight-bit scratch register stores and returns any written value.
// - divisor is high byte concatenated above low byte, sixteen bits.
// - at power-up divisor high byte is 00 and low byte is 01.
// - reset input leaves both divisor bytes unchanged.
// - reset clears ier, fcr, lcr, mcr; isr 01, lsr 60, scratch FF.
// - reset clears change flags; bits 7-4 show inverted modem inputs.
// - reset drives tx, rts, dtr, rx-ready high; tx-ready low; int per mode.
// - modem control bit 4 enters and leaves internal loopback.
// - lcr bit 7 set steers index 0 and 1 to the divisor bytes.
module uarx_regs (
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic POWER_UP_N,
  input wire logic [5:0] ADDRESS,
  input wire logic READ,
  input wire logic WRITE,
  input wire logic [31:0] WRITEDATA,
  input wire logic [3:0] BYTEENABLE,
  output logic [31:0] READDATA,
  output logic WAITREQUEST,
  input wire logic CTS_N,
  input wire logic DSR_N,
  input wire logic RI_N,
  input wire logic CARRIER_DETECT_IN,
  input wire logic INTERRUPT_STYLE_SELECT,
  input wire logic MODE68,
  input wire logic CONTINUOUS_INT,
  output logic TX,
  output logic RTS_N,
  output logic DTR_N,
  output logic RECEIVE_READY_OUT,
  output logic TRANSMIT_READY_OUT,
  output logic INT_O,
  output logic INT_OE,
  output logic IRQ_N,
  output logic [15:0] BAUD_DIVISOR,
  output logic IRQ
);
  logic [7:0] interrupt_enable_reg, fifo_control_reg, line_control_reg;
  logic [7:0] modem_control_reg, scratch_byte, interrupt_status_reg;
  logic [7:0] line_status_reg, divisor_low_byte, divisor_high_byte;
  logic [3:0] msr_delta, msr_status, deltas;
  logic [1:0] irq_stat, irq_mask;
  logic [7:0] next_ier, next_fcr, next_lcr, next_mcr, next_spr;
  logic [7:0] next_dll, next_dlm;
  logic [3:0] next_delta;
  logic [1:0] next_stat, next_mask;
  logic [31:0] next_rdata;
  logic [31:0] readdata_q;
  uarx_pkg::uarx_bus_t state, next_state;
  logic loop_on, take, wr, rd, lane0, div_sel;
  logic [3:0] idx;
  logic [7:0] msr_value;

  assign idx = ADDRESS[5:2];
  assign take = (state == uarx_pkg::UARX_IDLE) && (READ || WRITE);
  // a write lands on the completing edge, with waitrequest low
  assign wr = (state == uarx_pkg::UARX_ANSWER) && WRITE;
  assign rd = take && READ;
  assign lane0 = BYTEENABLE[0];
  assign div_sel = line_control_reg[uarx_pkg::LCR_DIV_EN];
  assign loop_on = modem_control_reg[uarx_pkg::MCR_LOOP];

  // status nibble: pins inverted, or mcr bits in loopback
  always_comb begin
    if (loop_on) begin
      msr_status = {modem_control_reg[uarx_pkg::MCR_OUT2],
        modem_control_reg[uarx_pkg::MCR_OUT1],
        modem_control_reg[uarx_pkg::MCR_DTR],
        modem_control_reg[uarx_pkg::MCR_RTS]};
    end else begin
      msr_status = {~CARRIER_DETECT_IN, ~RI_N, ~DSR_N, ~CTS_N};
    end
  end

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_delta
      uarx_edge u_edge (
        .CLK(CLK),
        .RESET_N(RESET_N),
        .level(msr_status[g]),
        .rise_only(g == 2),
        .changed(deltas[g]),
        .held()
      );
    end
  endgenerate

  assign msr_value = {msr_status, msr_delta};

  always_comb begin
    next_ier = interrupt_enable_reg;
    next_fcr = fifo_control_reg;
    next_lcr = line_control_reg;
    next_mcr = modem_control_reg;
    next_spr = scratch_byte;
    next_dll = divisor_low_byte;
    next_dlm = divisor_high_byte;
    next_mask = irq_mask;
    next_stat = irq_stat;
    next_delta = msr_delta;
    next_state = take ? uarx_pkg::UARX_ANSWER : uarx_pkg::UARX_IDLE;
    // read clears flags, but a change in the same cycle still sets
    if (rd && idx == {1'b0, uarx_pkg::IDX_MSR}) begin
      next_delta = 4'h0;
    end
    next_delta = next_delta | deltas;
    if (wr && lane0) begin
      case (idx)
        {1'b0, uarx_pkg::IDX_DATA}: begin
          if (div_sel) begin
            next_dll = WRITEDATA[7:0];
          end
        end
        {1'b0, uarx_pkg::IDX_IER}: begin
          if (div_sel) begin
            next_dlm = WRITEDATA[7:0];
          end else begin
            next_ier = WRITEDATA[7:0];
          end
        end
        {1'b0, uarx_pkg::IDX_ISR_FCR}: next_fcr = WRITEDATA[7:0];
        {1'b0, uarx_pkg::IDX_LCR}: next_lcr = WRITEDATA[7:0];
        {1'b0, uarx_pkg::IDX_MCR}: next_mcr = WRITEDATA[7:0];
        {1'b0, uarx_pkg::IDX_SPR}: next_spr = WRITEDATA[7:0];
        uarx_pkg::IDX_IRQ_STAT: next_stat = irq_stat & ~WRITEDATA[1:0];
        uarx_pkg::IDX_IRQ_MASK: next_mask = WRITEDATA[1:0];
        default: begin
        end
      endcase
    end
    // set wins over write-one-to-clear
    if (|deltas) begin
      next_stat[uarx_pkg::IRQ_MODEM] = 1'b1;
    end
    if (wr && lane0 && idx == {1'b0, uarx_pkg::IDX_SPR}) begin
      next_stat[uarx_pkg::IRQ_SCRATCH] = 1'b1;
    end
  end

  always_comb begin
    next_rdata = uarx_pkg::RD_UNMAPPED;
    case (idx)
      {1'b0, uarx_pkg::IDX_DATA}:
        next_rdata[7:0] = div_sel ? divisor_low_byte : 8'h00;
      {1'b0, uarx_pkg::IDX_IER}:
        next_rdata[7:0] = div_sel ? divisor_high_byte : interrupt_enable_reg;
      {1'b0, uarx_pkg::IDX_ISR_FCR}: next_rdata[7:0] = interrupt_status_reg;
      {1'b0, uarx_pkg::IDX_LCR}: next_rdata[7:0] = line_control_reg;
      {1'b0, uarx_pkg::IDX_MCR}: next_rdata[7:0] = modem_control_reg;
      {1'b0, uarx_pkg::IDX_LSR}: next_rdata[7:0] = line_status_reg;
      {1'b0, uarx_pkg::IDX_MSR}: next_rdata[7:0] = msr_value;
      {1'b0, uarx_pkg::IDX_SPR}: next_rdata[7:0] = scratch_byte;
      uarx_pkg::IDX_IRQ_STAT: next_rdata[1:0] = irq_stat;
      uarx_pkg::IDX_IRQ_MASK: next_rdata[1:0] = irq_mask;
      uarx_pkg::IDX_PINCTL: next_rdata[1:0] = {MODE68, CONTINUOUS_INT};
      default: next_rdata = uarx_pkg::RD_UNMAPPED;
    endcase
    if (!rd) begin
      next_rdata = readdata_q;
    end
  end

  // divisor bytes only see the power-up reset
  always_ff @(posedge CLK) begin
    if (!POWER_UP_N) begin
      divisor_low_byte <= uarx_pkg::RST_DLL;
      divisor_high_byte <= uarx_pkg::RST_DLM;
    end else begin
      divisor_low_byte <= next_dll;
      divisor_high_byte <= next_dlm;
    end
  end

  // power-up also forces the channel reset state
  always_ff @(posedge CLK) begin
    if (!RESET_N || !POWER_UP_N) begin
      interrupt_enable_reg <= uarx_pkg::RST_ZERO;
      fifo_control_reg <= uarx_pkg::RST_ZERO;
      line_control_reg <= uarx_pkg::RST_ZERO;
      modem_control_reg <= uarx_pkg::RST_ZERO;
      interrupt_status_reg <= uarx_pkg::RST_ISR;
      line_status_reg <= uarx_pkg::RST_LSR;
      scratch_byte <= uarx_pkg::RST_SPR;
      msr_delta <= 4'h0;
      irq_stat <= 2'h0;
      irq_mask <= 2'h0;
      state <= uarx_pkg::UARX_IDLE;
      readdata_q <= uarx_pkg::RD_UNMAPPED;
    end else begin
      interrupt_enable_reg <= next_ier;
      fifo_control_reg <= next_fcr;
      line_control_reg <= next_lcr;
      modem_control_reg <= next_mcr;
      interrupt_status_reg <= interrupt_status_reg;
      line_status_reg <= line_status_reg;
      scratch_byte <= next_spr;
      msr_delta <= next_delta;
      irq_stat <= next_stat;
      irq_mask <= next_mask;
      state <= next_state;
      readdata_q <= next_rdata;
    end
  end

  // one wait cycle lets read data come from a flip-flop
  assign WAITREQUEST = (READ || WRITE) && (state == uarx_pkg::UARX_IDLE);
  assign READDATA = readdata_q;
  assign BAUD_DIVISOR = {divisor_high_byte, divisor_low_byte};
  assign IRQ = |(irq_stat & irq_mask);

  // no datapath here: serial and ready pins sit at their idle levels
  assign TX = 1'b1;
  assign RTS_N = ~modem_control_reg[uarx_pkg::MCR_RTS] | loop_on;
  assign DTR_N = ~modem_control_reg[uarx_pkg::MCR_DTR] | loop_on;
  assign RECEIVE_READY_OUT = 1'b1;
  assign TRANSMIT_READY_OUT = 1'b0;
  // no pending uart interrupt source, so int sits inactive
  assign INT_O = 1'b0;
  assign INT_OE = MODE68 ? 1'b0 : (INTERRUPT_STYLE_SELECT || CONTINUOUS_INT
    || (modem_control_reg[uarx_pkg::MCR_OUT2] && !loop_on));
  assign IRQ_N = 1'b1;

  property p_cd_pin;
    @(posedge CLK) disable iff (!RESET_N)
    !loop_on |-> msr_value[uarx_pkg::MSR_CD] == !CARRIER_DETECT_IN;
  endproperty
  a_cd_pin: assert property (p_cd_pin)
    else $error("cd bit not inverted pin");
  property p_cd_loop;
    @(posedge CLK) disable iff (!RESET_N)
    loop_on |-> msr_value[uarx_pkg::MSR_CD] ==
      modem_control_reg[uarx_pkg::MCR_OUT2];
  endproperty
  a_cd_loop: assert property (p_cd_loop)
    else $error("cd bit not mcr bit 3 in loopback");
  property p_spr;
    @(posedge CLK) disable iff (!RESET_N)
    (wr && lane0 && idx == 4'h7) |=> scratch_byte == $past(WRITEDATA[7:0]);
  endproperty
  a_spr: assert property (p_spr) else $error("scratch not stored");
  property p_div_hold;
    @(posedge CLK) disable iff (!POWER_UP_N)
    !RESET_N |=> $stable(BAUD_DIVISOR);
  endproperty
  a_div_hold: assert property (p_div_hold)
    else $error("reset changed divisor");
  property p_pwr;
    @(posedge CLK) !POWER_UP_N |=> BAUD_DIVISOR == 16'h0001;
  endproperty
  a_pwr: assert property (p_pwr) else $error("power-up divisor");
  property p_rst;
    @(posedge CLK) !RESET_N |=> scratch_byte == 8'hFF &&
      line_status_reg == 8'h60 && interrupt_status_reg == 8'h01 &&
      modem_control_reg == 8'h00 && msr_delta == 4'h0 &&
      interrupt_enable_reg == 8'h00 && fifo_control_reg == 8'h00 &&
      line_control_reg == 8'h00;
  endproperty
  a_rst: assert property (p_rst) else $error("reset state wrong");
  sequence s_msr_read;
    rd && idx == 4'h6;
  endsequence
  property p_clr;
    @(posedge CLK) disable iff (!RESET_N)
    // a change in the read cycle itself still lands
    s_msr_read |=> msr_delta == $past(deltas);
  endproperty
  a_clr: assert property (p_clr) else $error("flags not cleared");
  property p_pins;
    @(posedge CLK) disable iff (!RESET_N)
    !loop_on && modem_control_reg[1:0] == 2'b00 |->
      RTS_N && DTR_N && TX && RECEIVE_READY_OUT && !TRANSMIT_READY_OUT;
  endproperty
  a_pins: assert property (p_pins) else $error("idle pins wrong");
  property p_dlsel;
    @(posedge CLK) disable iff (!RESET_N)
    (wr && lane0 && idx == 4'h0 && !div_sel) |=> $stable(divisor_low_byte);
  endproperty
  a_dlsel: assert property (p_dlsel)
    else $error("divisor written with lcr7 clear");
  // divisor bytes ignore the channel reset, so only power-up disables
  property p_dlwr;
    @(posedge CLK) disable iff (!POWER_UP_N)
    (wr && lane0 && idx == {1'b0, uarx_pkg::IDX_DATA} && div_sel) |=>
      divisor_low_byte == $past(WRITEDATA[7:0]);
  endproperty
  a_dlwr: assert property (p_dlwr)
    else $error("divisor low byte not written");
  property p_loop;
    @(posedge CLK) disable iff (!RESET_N)
    (wr && lane0 && idx == {1'b0, uarx_pkg::IDX_MCR}) |=>
      loop_on == $past(WRITEDATA[uarx_pkg::MCR_LOOP]);
  endproperty
  a_loop: assert property (p_loop)
    else $error("loopback not following mcr bit 4");
  property p_int_rst;
    @(posedge CLK) !RESET_N |=> !INT_O && IRQ_N &&
      INT_OE == (!MODE68 && (INTERRUPT_STYLE_SELECT || CONTINUOUS_INT));
  endproperty
  a_int_rst: assert property (p_int_rst)
    else $error("interrupt pin reset state wrong");
  sequence s_request;
    (READ || WRITE) && state == uarx_pkg::UARX_IDLE;
  endsequence
  property p_answer;
    @(posedge CLK) disable iff (!RESET_N)
    s_request |-> WAITREQUEST ##1 !WAITREQUEST;
  endproperty
  a_answer: assert property (p_answer)
    else $error("waitrequest not exactly one cycle");
  property p_scr_irq;
    @(posedge CLK) disable iff (!RESET_N)
    (wr && lane0 && idx == {1'b0, uarx_pkg::IDX_SPR}) |=>
      irq_stat[uarx_pkg::IRQ_SCRATCH];
  endproperty
  a_scr_irq: assert property (p_scr_irq)
    else $error("scratch event not flagged");
endmodule

// >>> inc/uarx_pkg.sv
package uarx_pkg;
  // register index map (byte address = index * 4)
  localparam logic [2:0] IDX_DATA = 3'h0;
  localparam logic [2:0] IDX_IER = 3'h1;
  localparam logic [2:0] IDX_ISR_FCR = 3'h2;
  localparam logic [2:0] IDX_LCR = 3'h3;
  localparam logic [2:0] IDX_MCR = 3'h4;
  localparam logic [2:0] IDX_LSR = 3'h5;
  localparam logic [2:0] IDX_MSR = 3'h6;
  localparam logic [2:0] IDX_SPR = 3'h7;
  localparam logic [3:0] IDX_IRQ_STAT = 4'h8;
  localparam logic [3:0] IDX_IRQ_MASK = 4'h9;
  localparam logic [3:0] IDX_PINCTL = 4'hA;
  // field positions
  localparam int LCR_DIV_EN = 7;
  localparam int MCR_DTR = 0;
  localparam int MCR_RTS = 1;
  localparam int MCR_OUT1 = 2;
  localparam int MCR_OUT2 = 3;
  localparam int MCR_LOOP = 4;
  localparam int MSR_CD = 7;
  // reset values
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_ISR = 8'h01;
  localparam logic [7:0] RST_LSR = 8'h60;
  localparam logic [7:0] RST_SPR = 8'hFF;
  localparam logic [7:0] RST_DLL = 8'h01;
  localparam logic [7:0] RST_DLM = 8'h00;
  localparam logic [31:0] RD_UNMAPPED = 32'h00000000;
  // interrupt status bits: 0 modem change, 1 scratch written
  localparam int IRQ_MODEM = 0;
  localparam int IRQ_SCRATCH = 1;
  typedef enum logic [1:0] {
    UARX_IDLE = 2'b00,
    UARX_ANSWER = 2'b01
  } uarx_bus_t;
endpackage

// >>> logic/uarx_edge.sv
module uarx_edge (
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic level,
  input wire logic rise_only,
  output logic changed,
  output logic held
);
  logic next_held;
  always_comb begin
    next_held = level;
  end
  always_ff @(posedge CLK) begin
    held <= next_held;
  end
  // ri only flags a low to high change of its status bit
  assign changed = RESET_N &&
    (rise_only ? (level & ~held) : (level ^ held));
endmodule

// >>> dv/uarx_host.sv
module uarx_host (
  input wire logic CLK,
  output logic [5:0] ADDRESS,
  output logic READ,
  output logic WRITE,
  output logic [31:0] WRITEDATA,
  output logic [3:0] BYTEENABLE,
  input wire logic [31:0] READDATA,
  input wire logic WAITREQUEST
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    ADDRESS = 6'h00;
    READ = 1'b0;
    WRITE = 1'b0;
    WRITEDATA = 32'h00000000;
    BYTEENABLE = 4'h0;
  end
  // request held until waitrequest seen low; no latency assumed
  task automatic xfer(input logic wr, input logic [3:0] idx,
      input logic [7:0] wd, output logic [7:0] rd);
    @(posedge CLK);
    ADDRESS <= {idx, 2'b00};
    READ <= ~wr;
    WRITE <= wr;
    WRITEDATA <= {24'h000000, wd};
    BYTEENABLE <= 4'hF;
    @(posedge CLK);
    while (WAITREQUEST !== 1'b0) @(posedge CLK);
    rd = READDATA[7:0];
    READ <= 1'b0;
    WRITE <= 1'b0;
  endtask
endmodule

// >>> dv/uart_aux_regs_and_reset_state_test.sv
module uart_aux_regs_and_reset_state_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic CLK, RESET_N, POWER_UP_N, READ, WRITE, WAITREQUEST;
  logic [5:0] ADDRESS;
  logic [31:0] WRITEDATA, READDATA;
  logic [3:0] BYTEENABLE;
  logic CTS_N, DSR_N, RI_N, CARRIER_DETECT_IN, INTERRUPT_STYLE_SELECT;
  logic MODE68, CONTINUOUS_INT, TX, RTS_N, DTR_N, RECEIVE_READY_OUT;
  logic TRANSMIT_READY_OUT, INT_O, INT_OE, IRQ_N, IRQ;
  logic [15:0] BAUD_DIVISOR;
  logic [7:0] v, lo, hi;
  logic [7:0] q [$];
  int error_cnt = 0;
  int checks_done = 0;
  int cyc = 0;
  bit [31:0] seed = 32'h00000059;
  wire [4:0] pinv = {TX, RTS_N, DTR_N, RECEIVE_READY_OUT, TRANSMIT_READY_OUT};
  wire [3:0] intv = {INT_OE, INT_O, IRQ_N, IRQ};
  uarx_host host (.CLK(CLK), .ADDRESS(ADDRESS), .READ(READ), .WRITE(WRITE),
    .WRITEDATA(WRITEDATA), .BYTEENABLE(BYTEENABLE), .READDATA(READDATA),
    .WAITREQUEST(WAITREQUEST));
  uarx_regs dut (.CLK(CLK), .RESET_N(RESET_N), .POWER_UP_N(POWER_UP_N),
    .ADDRESS(ADDRESS), .READ(READ), .WRITE(WRITE), .WRITEDATA(WRITEDATA),
    .BYTEENABLE(BYTEENABLE), .READDATA(READDATA), .WAITREQUEST(WAITREQUEST),
    .CTS_N(CTS_N), .DSR_N(DSR_N), .RI_N(RI_N),
    .CARRIER_DETECT_IN(CARRIER_DETECT_IN),
    .INTERRUPT_STYLE_SELECT(INTERRUPT_STYLE_SELECT), .MODE68(MODE68),
    .CONTINUOUS_INT(CONTINUOUS_INT), .TX(TX), .RTS_N(RTS_N), .DTR_N(DTR_N),
    .RECEIVE_READY_OUT(RECEIVE_READY_OUT),
    .TRANSMIT_READY_OUT(TRANSMIT_READY_OUT), .INT_O(INT_O), .INT_OE(INT_OE),
    .IRQ_N(IRQ_N), .BAUD_DIVISOR(BAUD_DIVISOR), .IRQ(IRQ));
  function automatic bit [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(input string nm, input logic [15:0] e, g);
    checks_done++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [3:0] i, input logic [7:0] d);
    host.xfer(1'b1, i, d, v);
    // write lands on the completing edge; let outputs settle
    @(posedge CLK);
  endtask
  task automatic rdc(input logic [3:0] i, input logic [7:0] e);
    host.xfer(1'b0, i, 8'h00, v);
    chk($sformatf("reg %0h", i), {8'h00, e}, {8'h00, v});
  endtask
  // modem status bits 7-4 follow the live pins, so expect them fresh
  task automatic regs();
    logic [7:0] e [8];
    e = '{8'h00, 8'h00, 8'h01, 8'h00, 8'h00, 8'h60,
      {~CARRIER_DETECT_IN, ~RI_N, ~DSR_N, ~CTS_N, 4'h0}, 8'hFF};
    for (int i = 0; i < 8; i++) rdc(i[3:0], e[i]);
  endtask
  task automatic pins();
    chk("pins", 16'h001E, {11'h0, pinv});
    chk("int", {12'h0, INTERRUPT_STYLE_SELECT, 3'b010}, {12'h0, intv});
  endtask
  task automatic complete_run();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    CLK = 1'b0;
    forever #50 CLK = ~CLK;
  end
  always @(posedge CLK) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      error_cnt++;
      complete_run();
    end
  end
  initial begin
    {RESET_N, POWER_UP_N, MODE68, CONTINUOUS_INT} = 4'h0;
    {INTERRUPT_STYLE_SELECT, CTS_N, DSR_N, RI_N, CARRIER_DETECT_IN} = 5'h05;
    repeat (10) @(posedge CLK);
    RESET_N <= 1'b1;
    POWER_UP_N <= 1'b1;
    @(posedge CLK);
    pins();
    chk("divisor", 16'h0001, BAUD_DIVISOR);
    regs();
    repeat (4) begin
      lo = 8'(xs());
      q.push_back(lo);
      wr(7, lo);
      rdc(7, q.pop_front());
    end
    wr(3, 8'h80);
    lo = 8'(xs());
    hi = 8'(xs());
    wr(0, lo);
    wr(1, hi);
    chk("divisor", {hi, lo}, BAUD_DIVISOR);
    rdc(0, lo);
    rdc(1, hi);
    wr(3, 8'h00);
    rdc(1, 8'h00);
    // drive modem outputs low so the channel reset has work to undo
    wr(4, 8'h03);
    INTERRUPT_STYLE_SELECT <= 1'b1;
    @(posedge CLK);
    RESET_N <= 1'b0;
    repeat (2) @(posedge CLK);
    RESET_N <= 1'b1;
    @(posedge CLK);
    pins();
    chk("divisor", {hi, lo}, BAUD_DIVISOR);
    regs();
    for (int k = 0; k < 8; k++) begin
      CARRIER_DETECT_IN <= k[0];
      wr(4, {3'h0, k[2:1], 3'h0});
      host.xfer(1'b0, 4'h6, 8'h00, v);
      chk("carrier", {15'h0, k[2] ? k[1] : ~k[0]}, {15'h0, v[7]});
    end
    wr(4, 8'h00);
    host.xfer(1'b0, 4'h6, 8'h00, v);
    CTS_N <= ~CTS_N;
    DSR_N <= ~DSR_N;
    host.xfer(1'b0, 4'h6, 8'h00, v);
    chk("flags", 16'h0003, {12'h0, v[3:0]});
    rdc(6, {~CARRIER_DETECT_IN, ~RI_N, ~DSR_N, ~CTS_N, 4'h0});
    wr(9, 8'h02);
    wr(8, 8'h03);
    chk("irq", 16'h0000, {15'h0, IRQ});
    wr(7, 8'h5A);
    chk("irq", 16'h0001, {15'h0, IRQ});
    rdc(8, 8'h02);
    wr(9, 8'h00);
    chk("irq", 16'h0000, {15'h0, IRQ});
    wr(9, 8'h02);
    wr(8, 8'h02);
    chk("irq", 16'h0000, {15'h0, IRQ});
    rdc(4'hB, 8'h00);
    wr(4'hB, 8'h77);
    rdc(7, 8'h5A);
    INTERRUPT_STYLE_SELECT <= 1'b0;
    CONTINUOUS_INT <= 1'b1;
    rdc(4'hA, 8'h01);
    chk("int", 16'h000A, {12'h0, intv});
    MODE68 <= 1'b1;
    rdc(4'hA, 8'h03);
    chk("int", 16'h0002, {12'h0, intv});
    complete_run();
  end
endmodule
